/* rtl/adc_cfg_pkg.sv */
// shared constants, field layouts and types of the converter configuration block
package adc_cfg_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 25;
  localparam int SETTLE_TIME_NS  = 100000;
  localparam int SETTLE_CYCLES   = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CNT_W    = 12;
  localparam logic [SETTLE_CNT_W-1:0] SETTLE_LOAD = SETTLE_CNT_W'(SETTLE_CYCLES);

  // ---------------------------------------------------------------
  // register layouts and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SFC_RESET      = 8'h00;
  localparam logic [7:0] TF_RESET       = 8'h00;
  localparam int         SFC_PD_BIT     = 4;
  localparam int         SFC_STREAM_BIT = 2;
  localparam int         TF_GAIN_MSB    = 7;
  localparam int         TF_GAIN_LSB    = 5;
  localparam int         TF_POL_BIT     = 4;
  localparam int         TF_DAC_MSB     = 3;
  localparam int         TF_DAC_SIGN    = 3;
  localparam int         TF_DAC_MAG_MSB = 2;
  localparam int         TF_COUNT       = 3;

  // register targets selected by the communications logic
  localparam logic [2:0] TGT_NONE = 3'h0;
  localparam logic [2:0] TGT_SFC  = 3'h1;
  localparam logic [2:0] TGT_TF1  = 3'h2;
  localparam logic [2:0] TGT_TF2  = 3'h3;
  localparam logic [2:0] TGT_TF3  = 3'h4;

  // offset dac step in tenths of a percent of full scale
  localparam logic [7:0] DAC_STEP_BIPOLAR  = 8'h53;
  localparam logic [7:0] DAC_STEP_UNIPOLAR = 8'ha7;

  // scan sequence last indices and calibration extension
  localparam logic [2:0] SEQ_LAST_PSEUDO = 3'h4;
  localparam logic [2:0] SEQ_LAST_PAIRS  = 3'h2;
  localparam logic [2:0] SEQ_CAL_EXTRA   = 3'h2;

  typedef enum logic [3:0] {
    ch_ain1_com, ch_ain2_com, ch_ain3_com, ch_ain4_com, ch_ain5_com,
    ch_pair12, ch_pair34, ch_pair56, ch_offset_cal, ch_gain_cal
  } chan_t;

  typedef enum logic {settling, data_ready} ready_state_t;

endpackage

/* rtl/tf_bank_if.sv */
// carrier between the control logic and the transfer-function register bank
`timescale 1ns/10ps
interface tf_bank_if;
  logic       wr_en;
  logic [1:0] wr_idx;
  logic [7:0] wr_data;
  logic [1:0] rd_idx;
  logic [7:0] rd_data;
  logic       wr_changes_word;

  modport bank (input wr_en, input wr_idx, input wr_data, input rd_idx,
                output rd_data, output wr_changes_word);
  modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx,
                input rd_data, input wr_changes_word);
endinterface

/* rtl/tf_register_bank.sv */
// three transfer-function registers with a registered read port
`timescale 1ns/10ps
module tf_register_bank
  import adc_cfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  tf_bank_if.bank  bus
);

  logic [7:0] word [0:TF_COUNT-1];
  wire        wr_idx_ok = (bus.wr_idx < 2'(TF_COUNT));
  wire        rd_idx_ok = (bus.rd_idx < 2'(TF_COUNT));

  genvar g;
  generate
    for (g = 0; g < TF_COUNT; g++) begin : g_word
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          word[g] <= TF_RESET;
        end else if (bus.wr_en && bus.wr_idx == 2'(g)) begin
          word[g] <= bus.wr_data;
        end
      end
    end
  endgenerate

  // lets the control side tell a real change from a rewrite of the same value
  assign bus.wr_changes_word = bus.wr_en && wr_idx_ok && (word[bus.wr_idx] != bus.wr_data);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bus.rd_data <= TF_RESET;
    end else begin
      bus.rd_data <= rd_idx_ok ? word[bus.rd_idx] : TF_RESET;
    end
  end

endmodule

/* rtl/adc_channel_config_control.sv */
// channel mapping, transfer-function and special-function control of the converter
//
// Contract
// RULE1: without scanning, channels offered follow pair mode and mode bits
// RULE2: host keeps reserved special-function bits at zero
// RULE3: stream bit routes modulator bits to data out, ready pin strobes falling
// RULE4: decimation filter keeps running while the modulator stream is exposed
// RULE5: full power-down stops device and oscillator until hardware reset
// RULE6: a mistaken special-function read needs twenty-four clocks from the host
// RULE7: transfer word holds gain, polarity, offset code, all zero after reset
// RULE8: gain equals two raised to the gain code
// RULE9: polarity 0 bipolar, 1 unipolar, digital coding only
// RULE10: polarity set before conversion, held results unaffected
// RULE11: offset code top bit sign, low three magnitude, step by polarity
// RULE12: zero offset magnitude disconnects the offset dac, the default
// RULE13: inputs 1-2 use register 1, 3-4 register 2, 5 register 3
// RULE14: non-scan decode of pair mode and selects; pair select 11 unused
// RULE15: selects pick calibration register unless scanning, then register 3
// RULE16: scan with unequal mode bits adds offset then gain calibration
// RULE17: active control change raises ready pin, resets filter, waits settling
// RULE18: writes to inactive channel settings disturb nothing
// RULE19: pseudo inputs against common, pair mode forms 1/2, 3/4, 5/6
// RULE20: mode 00 normal, 01 offset pair, 10 gain pair, 11 reserved
// RULE21: host writes each register as one byte, msb first
`timescale 1ns/10ps
module adc_channel_config_control
  import adc_cfg_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       serial_clk,
  input  wire logic       serial_din,
  input  wire logic       serial_cs_n,
  input  wire logic [2:0] reg_target,
  input  wire logic       scan_enable,
  input  wire logic       pair_mode_select,
  input  wire logic       mode_bit_high,
  input  wire logic       mode_bit_low,
  input  wire logic       chan_select_high,
  input  wire logic       chan_select_low,
  input  wire logic       conversion_done,
  input  wire logic       read_data_bit,
  input  wire logic       modulator_bit,
  input  wire logic       modulator_clk,
  output logic            serial_dout,
  output logic            data_ready_n,
  output logic            filter_reset,
  output logic            filter_run,
  output logic            osc_enable,
  output logic            full_power_down,
  output logic            modulator_stream_select,
  output logic [2:0]      amp_gain_code,
  output logic [7:0]      gain_factor,
  output logic            unipolar_coding,
  output logic [3:0]      offset_dac_code,
  output logic            dac_connect,
  output logic            dac_negative,
  output logic [7:0]      dac_step_tenths,
  output logic [2:0]      active_cid,
  output logic [1:0]      active_tf_sel,
  output logic            offset_cal_pair,
  output logic            gain_cal_pair
);

  // ---------------------------------------------------------------
  // decode functions
  // ---------------------------------------------------------------
  function automatic logic [1:0] tf_of(input chan_t ch, input logic scanning);
    case (ch)
      ch_ain1_com, ch_ain2_com, ch_pair12: tf_of = 2'd1;
      ch_ain3_com, ch_ain4_com, ch_pair34: tf_of = 2'd2;
      ch_ain5_com, ch_pair56:              tf_of = 2'd3;
      default:                             tf_of = scanning ? 2'd3 : 2'd0;
    endcase
  endfunction

  function automatic logic [2:0] cid_of(input chan_t ch);
    case (ch)
      ch_ain1_com: cid_of = 3'h0;
      ch_ain2_com: cid_of = 3'h1;
      ch_ain3_com: cid_of = 3'h2;
      ch_ain4_com: cid_of = 3'h3;
      ch_pair12:   cid_of = 3'h4;
      ch_pair34:   cid_of = 3'h5;
      ch_ain5_com: cid_of = 3'h6;
      ch_pair56:   cid_of = 3'h6;
      default:     cid_of = 3'h7;
    endcase
  endfunction

  function automatic chan_t input_of(input logic pairs, input logic [1:0] sel);
    case ({pairs, sel})
      3'b000:  input_of = ch_ain1_com;
      3'b001:  input_of = ch_ain2_com;
      3'b010:  input_of = ch_ain3_com;
      3'b011:  input_of = ch_ain4_com;
      3'b100:  input_of = ch_pair12;
      3'b101:  input_of = ch_pair34;
      default: input_of = ch_pair56;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // serial byte receiver
  // ---------------------------------------------------------------
  logic [2:0] pin_sync1;
  logic [2:0] pin_sync2;
  logic       sclk_prev;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic       byte_valid;
  logic [7:0] byte_data;

  wire sclk_s   = pin_sync2[0];
  wire din_s    = pin_sync2[1];
  wire cs_s     = ~pin_sync2[2];
  wire sclk_up  = sclk_s & ~sclk_prev;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pin_sync1 <= 3'h5;
      pin_sync2 <= 3'h5;
      sclk_prev <= 1'b1;
    end else begin
      pin_sync1 <= {serial_cs_n, serial_din, serial_clk};
      pin_sync2 <= pin_sync1;
      sclk_prev <= sclk_s;
    end
  end

  // bytes arrive msb first; the count restarts whenever the port is deselected
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bit_cnt    <= 3'h0;
      shift      <= 8'h00;
      byte_valid <= 1'b0;
      byte_data  <= 8'h00;
    end else begin
      byte_valid <= cs_s && sclk_up && bit_cnt == 3'h7;
      if (!cs_s) begin
        bit_cnt <= 3'h0;
      end else if (sclk_up) begin
        bit_cnt   <= bit_cnt + 3'h1;
        shift     <= {shift[6:0], din_s};
        byte_data <= {shift[6:0], din_s};
      end
    end
  end

  // ---------------------------------------------------------------
  // special-function register
  // ---------------------------------------------------------------
  // only defined bits are kept; reserved bits are the host's to keep zero
  wire sfc_write = byte_valid && reg_target == TGT_SFC;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      modulator_stream_select <= SFC_RESET[SFC_STREAM_BIT];
      full_power_down         <= SFC_RESET[SFC_PD_BIT];
    end else if (sfc_write) begin
      modulator_stream_select <= byte_data[SFC_STREAM_BIT];
      // sticky: clearing the bit does not wake the part, only reset does
      full_power_down <= full_power_down | byte_data[SFC_PD_BIT]; // RULE5
    end
  end

  // ---------------------------------------------------------------
  // channel mapping
  // ---------------------------------------------------------------
  tf_bank_if tf_bus ();

  logic [2:0] seq_idx;
  chan_t      idle_chan;
  chan_t      seq_chan;
  chan_t      active_chan;

  wire [1:0] mode     = {mode_bit_high, mode_bit_low};
  wire [1:0] sel      = {chan_select_high, chan_select_low};
  wire       cal_scan = mode_bit_high ^ mode_bit_low;
  wire [2:0] seq_inputs_last = pair_mode_select ? SEQ_LAST_PAIRS : SEQ_LAST_PSEUDO;
  wire [2:0] seq_last = cal_scan ? seq_inputs_last + SEQ_CAL_EXTRA : seq_inputs_last;
  wire       in_cal_tail = seq_idx > seq_inputs_last;
  wire [2:0] seq_input  = pair_mode_select ? (seq_idx + 3'h5) : seq_idx;

  // non-scan: mode bits pick normal, offset pair or gain pair
  always_comb begin
    case (mode)
      2'b01:   idle_chan = ch_offset_cal; // RULE20 RULE1
      2'b10:   idle_chan = ch_gain_cal; // RULE20 RULE1
      default: idle_chan = input_of(pair_mode_select, sel); // RULE14 RULE19
    endcase
  end

  // scan: inputs in order, then offset calibration ahead of gain calibration
  always_comb begin
    if (in_cal_tail) begin
      seq_chan = (seq_idx == seq_inputs_last + 3'h1) ? ch_offset_cal : ch_gain_cal; // RULE16
    end else begin
      seq_chan = chan_t'({1'b0, seq_input}); // RULE19
    end
  end

  assign active_chan = scan_enable ? seq_chan : idle_chan;

  // calibration channels borrow the register of the selected input when idle
  wire [1:0] idle_tf   = tf_of(input_of(pair_mode_select, sel), 1'b0); // RULE15
  wire [1:0] next_tf   = (!scan_enable && (active_chan == ch_offset_cal
                          || active_chan == ch_gain_cal)) ? idle_tf
                         : tf_of(active_chan, scan_enable); // RULE13 RULE15
  wire [5:0] glob      = {scan_enable, pair_mode_select, mode, sel};
  logic [5:0] glob_q;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      seq_idx <= 3'h0;
      glob_q  <= 6'h00;
    end else begin
      glob_q <= glob;
      if (glob != glob_q || !scan_enable) begin
        seq_idx <= 3'h0;
      end else if (conversion_done) begin
        seq_idx <= (seq_idx >= seq_last) ? 3'h0 : seq_idx + 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // transfer-function registers
  // ---------------------------------------------------------------
  wire [2:0] tgt_rel = reg_target - TGT_TF1;

  assign tf_bus.wr_en   = byte_valid && reg_target >= TGT_TF1 && reg_target <= TGT_TF3;
  assign tf_bus.wr_idx  = tgt_rel[1:0];
  assign tf_bus.wr_data = byte_data;
  assign tf_bus.rd_idx  = next_tf - 2'd1;

  tf_register_bank u_tf_bank (
    .ref_clk (ref_clk),
    .reset   (reset),
    .bus     (tf_bus.bank)
  );

  // only a real change of the register that the active channel uses counts
  wire active_hit = tf_bus.wr_changes_word && (tf_bus.wr_idx == next_tf - 2'd1); // RULE18
  wire restart    = (glob != glob_q) || active_hit; // RULE17
  wire [7:0] tfw  = tf_bus.rd_data;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      amp_gain_code   <= TF_RESET[TF_GAIN_MSB:TF_GAIN_LSB];
      gain_factor     <= 8'h01;
      offset_dac_code <= TF_RESET[TF_DAC_MSB:0];
      dac_connect     <= 1'b0;
      dac_negative    <= 1'b0;
      dac_step_tenths <= DAC_STEP_BIPOLAR;
      active_cid      <= 3'h0;
      active_tf_sel   <= 2'd1;
      offset_cal_pair <= 1'b0;
      gain_cal_pair   <= 1'b0;
    end else begin
      amp_gain_code   <= tfw[TF_GAIN_MSB:TF_GAIN_LSB]; // RULE7
      gain_factor     <= 8'h01 << tfw[TF_GAIN_MSB:TF_GAIN_LSB]; // RULE8
      offset_dac_code <= tfw[TF_DAC_MSB:0]; // RULE7
      dac_connect     <= tfw[TF_DAC_MAG_MSB:0] != 3'h0; // RULE12
      dac_negative    <= tfw[TF_DAC_SIGN]; // RULE11
      dac_step_tenths <= tfw[TF_POL_BIT] ? DAC_STEP_UNIPOLAR : DAC_STEP_BIPOLAR; // RULE11
      active_cid      <= cid_of(active_chan);
      active_tf_sel   <= next_tf;
      offset_cal_pair <= active_chan == ch_offset_cal;
      gain_cal_pair   <= active_chan == ch_gain_cal;
    end
  end

  // coding is taken at a conversion boundary, so a late change spares held data;
  // the bank read port lags a write or a channel step by two cycles
  logic [1:0] coding_take_q;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      coding_take_q   <= 2'h0;
      unipolar_coding <= TF_RESET[TF_POL_BIT];
    end else begin
      coding_take_q <= {coding_take_q[0], restart || conversion_done};
      if (coding_take_q[1]) begin
        unipolar_coding <= tfw[TF_POL_BIT]; // RULE9 RULE10
      end
    end
  end

  // ---------------------------------------------------------------
  // settling, data ready and output pins
  // ---------------------------------------------------------------
  ready_state_t            rdy_state;
  logic [SETTLE_CNT_W-1:0] settle_cnt;
  logic                    mod_clk_prev;
  logic                    stream_bit;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdy_state  <= settling;
      settle_cnt <= SETTLE_LOAD;
    end else begin
      case (rdy_state)
        settling: begin
          if (restart) begin
            settle_cnt <= SETTLE_LOAD; // RULE17
          end else if (settle_cnt == 1) begin
            rdy_state <= data_ready;
          end else begin
            settle_cnt <= settle_cnt - 1'b1;
          end
        end
        data_ready: begin
          if (restart) begin
            rdy_state  <= settling; // RULE17
            settle_cnt <= SETTLE_LOAD;
          end
        end
        default: rdy_state <= settling;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mod_clk_prev <= 1'b0;
      stream_bit   <= 1'b0;
      serial_dout  <= 1'b0;
      data_ready_n <= 1'b1;
      filter_reset <= 1'b0;
      filter_run   <= 1'b1;
      osc_enable   <= 1'b1;
    end else begin
      mod_clk_prev <= modulator_clk;
      // new stream bit is launched on the rising strobe, sampled at the fall
      if (modulator_clk && !mod_clk_prev) begin
        stream_bit <= modulator_bit;
      end
      serial_dout  <= modulator_stream_select ? stream_bit : read_data_bit; // RULE3
      data_ready_n <= modulator_stream_select ? modulator_clk
                    : (restart || rdy_state != data_ready); // RULE3 RULE17
      filter_reset <= restart; // RULE17
      filter_run   <= !full_power_down; // RULE4 RULE5
      osc_enable   <= !full_power_down; // RULE5
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_restart_ready_high: assert property ( // RULE17
    restart && !modulator_stream_select |=> data_ready_n && filter_reset)
    else $error("active change did not raise ready and reset filter");
  a_settle_before_ready: assert property ( // RULE17
    restart && !modulator_stream_select |=> data_ready_n [*8])
    else $error("ready returned before settling");
  a_inactive_write_quiet: assert property ( // RULE18
    tf_bus.wr_en && !active_hit && glob == glob_q |=> !filter_reset)
    else $error("inactive write reset the filter");
  a_power_down_sticky: assert property ( // RULE5
    full_power_down |=> full_power_down && !osc_enable)
    else $error("power-down left without reset");
  a_stream_filter_runs: assert property ( // RULE4
    modulator_stream_select && !full_power_down |-> ##1 filter_run)
    else $error("filter stopped during stream output");
  a_stream_data_pin: assert property ( // RULE3
    modulator_stream_select && $rose(modulator_clk) ##1 modulator_stream_select
      |=> serial_dout == $past(modulator_bit, 2))
    else $error("stream bit not on data pin");
  a_gain_power_two: assert property ( // RULE8
    gain_factor == (8'h01 << amp_gain_code))
    else $error("gain factor mismatch");
  a_dac_disconnect: assert property ( // RULE12
    dac_connect == (offset_dac_code[2:0] != 3'h0))
    else $error("offset dac connection wrong");
  a_scan_cal_register: assert property ( // RULE15
    scan_enable && (active_chan == ch_offset_cal || active_chan == ch_gain_cal)
      |=> active_tf_sel == 2'd3)
    else $error("scan calibration not on register 3");
  a_scan_cal_order: assert property ( // RULE16
    scan_enable && active_chan == ch_offset_cal && conversion_done && glob == glob_q
      |=> active_chan == ch_gain_cal)
    else $error("gain calibration did not follow offset calibration");
  a_input_register_map: assert property ( // RULE13
    active_chan == ch_ain1_com || active_chan == ch_pair12 |=> active_tf_sel == 2'd1)
    else $error("inputs one and two not on register 1");

  c_scan_calibration: cover property (scan_enable && cal_scan && active_chan == ch_gain_cal);
  c_stream_output:    cover property (modulator_stream_select && $fell(data_ready_n));
  c_settled:          cover property (rdy_state == settling ##1 rdy_state == data_ready);
  c_power_down:       cover property ($rose(full_power_down));

endmodule

/* testbench/host_serial_model.sv */
// host microcontroller model writing bytes on the three-wire serial port
`timescale 1ns/10ps
module host_serial_model (
  output logic serial_clk,
  output logic serial_din,
  output logic serial_cs_n
);
  initial begin
    serial_clk  = 1'h1;
    serial_din  = 1'h0;
    serial_cs_n = 1'h1;
  end

  // the link clock stands still between frames; data flips once deselected
  // so a stale bit can never pass for a fresh one
  task automatic send(input logic [7:0] b);
    serial_cs_n = 1'h0;
    for (int i = 7; i >= 0; i--) begin
      serial_clk = 1'h0;
      serial_din = b[i];
      #100;
      serial_clk = 1'h1;
      #100;
    end
    serial_cs_n = 1'h1;
    serial_din  = ~serial_din;
  endtask

  // a stray read of the write-only register is flushed with 24 clocks in one frame
  task automatic flush_read();
    serial_cs_n = 1'h0;
    repeat (24) begin
      serial_clk = 1'h0;
      #100;
      serial_clk = 1'h1;
      #100;
    end
    serial_cs_n = 1'h1;
  endtask
endmodule

/* testbench/adc_channel_config_control_bench.sv */
// self-checking bench of the converter configuration block
`timescale 1ns/10ps
module adc_channel_config_control_bench;
  import adc_cfg_pkg::*;
  logic       ref_clk, reset, serial_clk, serial_din, serial_cs_n;
  logic [2:0] reg_target, amp_gain_code, active_cid;
  logic       scan_enable, pair_mode_select, mode_bit_high, mode_bit_low;
  logic       chan_select_high, chan_select_low, conversion_done;
  logic       read_data_bit, modulator_bit, modulator_clk, serial_dout;
  logic       data_ready_n, filter_reset, filter_run, osc_enable;
  logic       full_power_down, modulator_stream_select, unipolar_coding;
  logic       dac_connect, dac_negative, offset_cal_pair, gain_cal_pair, d, b;
  logic [7:0] gain_factor, dac_step_tenths, w, w3;
  logic [3:0] offset_dac_code;
  logic [1:0] active_tf_sel;
  logic [4:0] e;
  int         n_errors, cmp_count, n_rst, r, len;

  adc_channel_config_control DUT (.ref_clk, .reset, .serial_clk, .serial_din,
    .serial_cs_n, .reg_target, .scan_enable, .pair_mode_select, .mode_bit_high,
    .mode_bit_low, .chan_select_high, .chan_select_low, .conversion_done,
    .read_data_bit, .modulator_bit, .modulator_clk, .serial_dout, .data_ready_n,
    .filter_reset, .filter_run, .osc_enable, .full_power_down,
    .modulator_stream_select, .amp_gain_code, .gain_factor, .unipolar_coding,
    .offset_dac_code, .dac_connect, .dac_negative, .dac_step_tenths, .active_cid,
    .active_tf_sel, .offset_cal_pair, .gain_cal_pair);
  host_serial_model host (.serial_clk, .serial_din, .serial_cs_n);

  always #12.5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (filter_reset === 1'h1) n_rst++;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] t, input logic [7:0] v);
    reg_target = t;
    host.send(v);
    cyc(10);
    reg_target = TGT_NONE;
    cyc(2);
  endtask
  task automatic check_tf(input logic [7:0] v);
    check(amp_gain_code, v[7:5]);
    check(gain_factor, 8'h01 << v[7:5]);
    check(unipolar_coding, v[4]);
    check(offset_dac_code, v[3:0]);
    check(dac_negative, v[3]);
    check(dac_connect, v[2:0] != 3'h0);
    check(dac_step_tenths, v[4] ? 8'ha7 : 8'h53);
  endtask
  function automatic logic [4:0] exp_map(input logic pd, input logic [1:0] a, input logic cal);
    logic [1:0] tf;
    logic [2:0] cid;
    tf  = pd ? a + 2'h1 : (a[1] ? 2'h2 : 2'h1);
    cid = cal ? 3'h7 : (pd ? 3'h4 + 3'(a) : {1'h0, a});
    return {tf, cid};
  endfunction
  function automatic logic [4:0] exp_scan(input logic pd, input int i);
    if (i >= (pd ? 3 : 5)) return {2'h3, 3'h7};
    if (pd) return {2'(i + 1), 3'(i + 4)};
    return {(i < 2) ? 2'h1 : (i < 4) ? 2'h2 : 2'h3, (i == 4) ? 3'h6 : 3'(i)};
  endfunction
  task automatic complete_run();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #(60000 * 25);
    n_errors++;
    complete_run();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'h0;
    reset = 1'h1;
    reg_target = TGT_NONE;
    {scan_enable, pair_mode_select, mode_bit_high, mode_bit_low} = 4'h0;
    {chan_select_high, chan_select_low, conversion_done} = 3'h0;
    {read_data_bit, modulator_bit, modulator_clk} = 3'h0;
    n_errors = 0;
    cmp_count = 0;
    n_rst = 0;
    w = 8'($urandom(64159));
    cyc(5);
    reset = 1'h0;
    cyc(2);
    check_tf(TF_RESET);
    check(data_ready_n, 8'h01);
    check(active_tf_sel, 8'h01);
    r = n_rst;
    chan_select_low = 1'h1;
    cyc(3);
    check(8'(n_rst - r), 8'h01);
    cyc(SETTLE_CYCLES - 8);
    check(data_ready_n, 8'h01);
    cyc(16);
    check(data_ready_n, 8'h00);
    w3 = 8'($urandom);
    r = n_rst;
    wr(TGT_TF3, w3);
    check(8'(n_rst - r), 8'h00);
    check(data_ready_n, 8'h00);
    repeat (6) begin
      w = 8'($urandom);
      wr(TGT_TF1, w);
      check_tf(w);
    end
    for (int i = 0; i < 24; i++) begin
      if (i[4:3] == 2'h3 || (i[2] && i[1:0] == 2'h3)) continue;
      {mode_bit_high, mode_bit_low} = i[4:3];
      pair_mode_select = i[2];
      {chan_select_high, chan_select_low} = i[1:0];
      cyc(6);
      e = exp_map(i[2], i[1:0], i[4:3] != 2'h0);
      check(active_tf_sel, e[4:3]);
      check(active_cid, e[2:0]);
      check(offset_cal_pair, i[4:3] == 2'h1);
      check(gain_cal_pair, i[4:3] == 2'h2);
      if (e[4:3] == 2'h3) check_tf(w3);
    end
    scan_enable = 1'h1;
    for (int k = 0; k < 4; k++) begin
      d = k[0];
      pair_mode_select = d;
      {mode_bit_high, mode_bit_low} = k[1] ? (d ? 2'h1 : 2'h2) : 2'h0;
      len = (d ? 3 : 5) + (k[1] ? 2 : 0);
      cyc(6);
      for (int i = 0; i < 8; i++) begin
        e = exp_scan(d, i % len);
        check(active_tf_sel, e[4:3]);
        check(active_cid, e[2:0]);
        check(offset_cal_pair, k[1] && (i % len) == len - 2);
        check(gain_cal_pair, k[1] && (i % len) == len - 1);
        conversion_done = 1'h1;
        cyc(1);
        conversion_done = 1'h0;
        cyc(5);
      end
    end
    scan_enable = 1'h0;
    wr(TGT_SFC, 8'h01 << SFC_STREAM_BIT);
    check(modulator_stream_select, 8'h01);
    repeat (6) begin
      b = 1'($urandom);
      modulator_bit = b;
      cyc(1);
      modulator_clk = 1'h1;
      cyc(4);
      check(serial_dout, b);
      check(data_ready_n, 8'h01);
      modulator_clk = 1'h0;
      modulator_bit = ~b;
      cyc(4);
      check(data_ready_n, 8'h00);
      check(filter_run, 8'h01);
    end
    wr(TGT_SFC, 8'h00);
    r = n_rst;
    host.flush_read();
    cyc(12);
    check(8'(n_rst - r), 8'h00);
    check(modulator_stream_select, 8'h00);
    check(full_power_down, 8'h00);
    repeat (4) begin
      b = 1'($urandom);
      read_data_bit = b;
      cyc(3);
      check(serial_dout, b);
    end
    wr(TGT_SFC, 8'h01 << SFC_PD_BIT);
    check(full_power_down, 8'h01);
    check(osc_enable, 8'h00);
    check(filter_run, 8'h00);
    wr(TGT_SFC, 8'h00);
    check(full_power_down, 8'h01);
    reset = 1'h1;
    cyc(2);
    reset = 1'h0;
    cyc(2);
    check(osc_enable, 8'h01);
    check_tf(TF_RESET);
    complete_run();
  end
endmodule
